// [rgf_pkg.sv]
// Purpose: Shared constants for the range-gated filter block
// Assumes: One 50 MHz core clock, synchronous active-high reset
// Notes:   History word layout and FIFO sizing live here
//
// Functional notes
// - Keep history for 4096 bins, share arithmetic
// - Process each range increment with its bin history
// - Output is four tap products summed
// - Non-recursive mode: inputs only, no feedback
// - Recursive mode adds weighted earlier bin outputs
// - History read and written on separate paths
// - Registers sit at history memory input/output
package rgf_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Bin addressing
    localparam int          BIN_CNT  = 4096;          // Range bins per sweep
    localparam int          BIN_W    = 12;            // Bin index width
    localparam logic [11:0] BIN_LAST = 12'hFFF;       // Highest bin index
    localparam logic [11:0] BIN_ONE  = 12'h001;       // Bin increment

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath widths
    localparam int SMP_W  = 16;                       // Sample and coefficient width
    localparam int PROD_W = 32;                       // One product
    localparam int ACC_W  = 36;                       // Sum with guard bits
    localparam int FRAC   = 14;                       // Coefficient fraction bits

    ////////////////////////////////////////////////////////////////////////////////
    // History word: x1, x2, x3 prior inputs, y1, y2 prior outputs
    localparam int H_X1   = 0;                        // First prior sample
    localparam int H_X2   = 16;                       // Second prior sample
    localparam int H_X3   = 32;                       // Third prior sample
    localparam int H_Y1   = 48;                       // Last stored output
    localparam int H_Y2   = 64;                       // Output before that
    localparam int HIST_W = 80;                       // Whole history word
    localparam logic [79:0] HIST_RST = 80'h0;         // Cleared history

    ////////////////////////////////////////////////////////////////////////////////
    // Output FIFO
    localparam int         FIFO_DEPTH = 16;           // Array words; head register holds one more
    localparam int         FIFO_W     = 48;           // Bin index plus sum
    localparam int         LVL_W      = 5;            // FIFO level width
    localparam logic [4:0] READY_MAX  = 5'h0D;        // Level that still admits input

    // Pipeline phase
    typedef enum logic {RGF_CLEAR, RGF_RUN} rgf_state_t;
endpackage

// [rgf_store.sv]
// Purpose: History memory and output FIFO for the range-gated filter
// Assumes: Single clock, synchronous active-high reset
// Notes:   Both stores present read data from a register

////////////////////////////////////////////////////////////////////////////////
// Two-port history memory, read port independent of write port
module rgf_hist_ram #(
    parameter int AW = 12,                         // Address width
    parameter int DW = 80                          // Data width
) (
    input  wire logic          core_clk,           // Core clock
    input  wire logic          wr_en,              // Write strobe
    input  wire logic [AW-1:0] wr_addr,            // Write address
    input  wire logic [DW-1:0] wr_data,            // Write data
    input  wire logic          rd_en,              // Read strobe
    input  wire logic [AW-1:0] rd_addr,            // Read address
    output logic      [DW-1:0] rd_data             // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];              // Storage array

    // Write port
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port, returns old data on a colliding write
    always_ff @(posedge core_clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// FIFO with registered head word
module rgf_fifo #(
    parameter int W     = 48,                      // Word width
    parameter int DEPTH = 16,                      // Array depth
    parameter int LW    = 5                        // Level width
) (
    input  wire logic          core_clk,           // Core clock
    input  wire logic          srst,               // Synchronous reset
    input  wire logic          s_valid,            // Write valid
    output logic               s_ready,            // Room in array
    input  wire logic [W-1:0]  s_data,             // Write data
    output logic               m_valid,            // Head word valid
    input  wire logic          m_ready,            // Head word taken
    output logic      [W-1:0]  m_data,             // Head word
    output logic      [LW-1:0] level               // Words held
);
    localparam int PW = $clog2(DEPTH);             // Pointer width

    logic [W-1:0]  mem [0:DEPTH-1];                // Storage array
    logic [PW-1:0] wp_q;                           // Write pointer
    logic [PW-1:0] rp_q;                           // Read pointer
    logic [LW-1:0] cnt_q;                          // Words in array
    logic          push;                           // Array write
    logic          load;                           // Move array to head

    assign s_ready = (cnt_q < LW'(DEPTH));
    assign push    = s_valid && s_ready;
    assign load    = (cnt_q != '0) && (!m_valid || m_ready);
    assign level   = cnt_q + LW'(m_valid);

    // Array write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_q] <= s_data;
        end
    end

    // Pointers, count and head register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            m_valid <= 1'b0;
            m_data  <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + PW'(1);
            end
            if (load) begin
                rp_q   <= rp_q + PW'(1);
                m_data <= mem[rp_q];
            end
            cnt_q <= cnt_q + LW'(push) - LW'(load);
            if (load) begin
                m_valid <= 1'b1;
            end else if (m_ready) begin
                m_valid <= 1'b0;
            end
        end
    end
endmodule

// [rgf_filter.sv]
// Purpose: Range-gated four-tap filter with optional recursive feedback
// Assumes: Samples and coefficients come from logic on core_clk
// Notes:   History memory is cleared after reset before input is taken

module rgf_filter
    import rgf_pkg::*;
(
    input  wire logic                    core_clk,       // Core clock, 50 MHz
    input  wire logic                    srst,           // Synchronous reset
    input  wire logic                    smp_valid,      // Sample offered
    output logic                         smp_ready,      // Sample can be taken
    input  wire logic signed [SMP_W-1:0] smp_data,       // Digitized sample
    input  wire logic                    sweep_start,    // Sample is first bin of sweep
    input  wire logic                    mode_recursive, // Add feedback terms
    input  wire logic signed [SMP_W-1:0] coef_tap0,      // Present sample weight
    input  wire logic signed [SMP_W-1:0] coef_tap1,      // First prior weight
    input  wire logic signed [SMP_W-1:0] coef_tap2,      // Second prior weight
    input  wire logic signed [SMP_W-1:0] coef_tap3,      // Third prior weight
    input  wire logic signed [SMP_W-1:0] coef_fb1,       // Last output weight
    input  wire logic signed [SMP_W-1:0] coef_fb2,       // Older output weight
    output logic                         out_valid,      // Result available
    input  wire logic                    out_ready,      // Result taken
    output logic             [ACC_W-1:0] out_data,       // Filtered value
    output logic             [BIN_W-1:0] out_bin         // Bin of the result
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Signed product widened to the sum width
    function automatic logic signed [ACC_W-1:0] mulw(input logic signed [SMP_W-1:0] a,
                                                     input logic signed [SMP_W-1:0] b);
        logic signed [PROD_W-1:0] p;
        p    = a * b;
        mulw = ACC_W'(p);
    endfunction

    // Scale a sum back to sample range with saturation
    function automatic logic signed [SMP_W-1:0] sat(input logic signed [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] s;
        s = v >>> FRAC;
        if (s > ACC_W'(32767)) begin
            sat = 16'h7FFF;
        end else if (s < -ACC_W'(32768)) begin
            sat = 16'h8000;
        end else begin
            sat = s[SMP_W-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    rgf_state_t                st_q;             // Clear or run
    logic [BIN_W-1:0]          clr_q;            // Clear address
    logic                      smp_ready_q;      // Registered input ready
    logic [BIN_W-1:0]          bin_q;            // Next bin expected
    logic                      s1_v_q;           // Compute stage valid
    logic signed [SMP_W-1:0]   s1_x_q;           // Present sample
    logic [BIN_W-1:0]          s1_bin_q;         // Present bin
    logic                      wr_en_q;          // Write register stage
    logic [BIN_W-1:0]          wr_addr_q;        // Write address
    logic [HIST_W-1:0]         wr_data_q;        // Write data
    logic                      wr2_en_q;         // Write one cycle older
    logic [BIN_W-1:0]          wr2_addr_q;       // Its address
    logic [HIST_W-1:0]         wr2_data_q;       // Its data
    logic [HIST_W-1:0]         rd_data;          // Memory read register
    logic [LVL_W-1:0]          fifo_level;       // FIFO occupancy
    logic                      fifo_s_ready;     // FIFO room

    wire                       accept;           // Sample taken this cycle
    wire [BIN_W-1:0]           cur_bin;          // Bin of offered sample
    wire                       fwd1;             // Newest write hits bin
    wire                       fwd2;             // Older write hits bin
    wire [HIST_W-1:0]          hist;             // Up-to-date history
    wire signed [SMP_W-1:0]    h_x1;             // First prior sample
    wire signed [SMP_W-1:0]    h_x2;             // Second prior sample
    wire signed [SMP_W-1:0]    h_x3;             // Third prior sample
    wire signed [SMP_W-1:0]    h_y1;             // Last output
    wire signed [SMP_W-1:0]    h_y2;             // Older output
    wire signed [ACC_W-1:0]    fir_sum;          // Input terms
    wire signed [ACC_W-1:0]    fb_sum;           // Feedback terms
    wire signed [ACC_W-1:0]    acc;              // Result
    wire signed [SMP_W-1:0]    y_st;             // Stored output
    wire [HIST_W-1:0]          new_hist;         // Shifted history
    wire                       clr_done;         // Last clear write
    wire                       ready_d;          // Next input ready

    ////////////////////////////////////////////////////////////////////////////////
    // Input acceptance and bin tracking
    assign accept   = smp_valid && smp_ready_q;
    assign cur_bin  = sweep_start ? '0 : bin_q;
    assign clr_done = (clr_q == BIN_LAST);
    assign ready_d  = (st_q == RGF_RUN) && (fifo_level <= READY_MAX);
    assign smp_ready = smp_ready_q;

    // Clear every bin after reset, then run
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q  <= RGF_CLEAR;
            clr_q <= '0;
        end else begin
            case (st_q)
                RGF_CLEAR: begin                                     // Zero history
                    clr_q <= clr_q + BIN_ONE;
                    if (clr_done) begin
                        st_q <= RGF_RUN;
                    end
                end
                RGF_RUN: begin                                       // Normal flow
                    st_q <= RGF_RUN;
                end
                default: begin
                    st_q <= RGF_CLEAR;
                end
            endcase
        end
    end

    // Ready and next bin; index wraps after the last bin
    always_ff @(posedge core_clk) begin
        if (srst) begin
            smp_ready_q <= 1'b0;
            bin_q       <= '0;
        end else begin
            smp_ready_q <= ready_d;
            if (accept) begin
                bin_q <= cur_bin + BIN_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // History memory, one word per bin
    rgf_hist_ram #(
        .AW (BIN_W),
        .DW (HIST_W)
    ) u_hist (
        .core_clk (core_clk),
        .wr_en    (wr_en_q),
        .wr_addr  (wr_addr_q),
        .wr_data  (wr_data_q),
        .rd_en    (accept),
        .rd_addr  (cur_bin),
        .rd_data  (rd_data)
    );

    // Compute stage register, read data arrives alongside
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_v_q   <= 1'b0;
            s1_x_q   <= '0;
            s1_bin_q <= '0;
        end else begin
            s1_v_q <= accept;
            if (accept) begin
                s1_x_q   <= smp_data;
                s1_bin_q <= cur_bin;
            end
        end
    end

    // Writes not yet seen by the read are forwarded, newest first
    assign fwd1 = wr_en_q && (wr_addr_q == s1_bin_q);
    assign fwd2 = wr2_en_q && (wr2_addr_q == s1_bin_q);
    assign hist = fwd1 ? wr_data_q : (fwd2 ? wr2_data_q : rd_data);

    ////////////////////////////////////////////////////////////////////////////////
    // Shared multiply-and-add datapath
    assign h_x1 = hist[H_X1 +: SMP_W];
    assign h_x2 = hist[H_X2 +: SMP_W];
    assign h_x3 = hist[H_X3 +: SMP_W];
    assign h_y1 = hist[H_Y1 +: SMP_W];
    assign h_y2 = hist[H_Y2 +: SMP_W];

    assign fir_sum = mulw(coef_tap0, s1_x_q) + mulw(coef_tap1, h_x1)
                   + mulw(coef_tap2, h_x2) + mulw(coef_tap3, h_x3);
    assign fb_sum  = mulw(coef_fb1, h_y1) + mulw(coef_fb2, h_y2);
    assign acc     = mode_recursive ? (fir_sum + fb_sum) : fir_sum;
    assign y_st    = sat(acc);
    assign new_hist = {h_y1, y_st, h_x2, h_x1, s1_x_q};

    // Registered write side of the memory, cleared bins first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_en_q    <= 1'b0;
            wr_addr_q  <= '0;
            wr_data_q  <= HIST_RST;
            wr2_en_q   <= 1'b0;
            wr2_addr_q <= '0;
            wr2_data_q <= HIST_RST;
        end else begin
            if (st_q == RGF_CLEAR) begin                             // Clear sweep
                wr_en_q   <= 1'b1;
                wr_addr_q <= clr_q;
                wr_data_q <= HIST_RST;
            end else begin                                           // Shifted history
                wr_en_q   <= s1_v_q;
                wr_addr_q <= s1_bin_q;
                wr_data_q <= new_hist;
            end
            wr2_en_q   <= wr_en_q;
            wr2_addr_q <= wr_addr_q;
            wr2_data_q <= wr_data_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output FIFO; ready margin covers the three words in flight
    rgf_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH),
        .LW    (LVL_W)
    ) u_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .s_valid  (s1_v_q),
        .s_ready  (fifo_s_ready),
        .s_data   ({s1_bin_q, acc}),
        .m_valid  (out_valid),
        .m_ready  (out_ready),
        .m_data   ({out_bin, out_data}),
        .level    (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_bin_step:
    assert property (accept && !sweep_start && bin_q != BIN_LAST |=>
                     bin_q == $past(bin_q) + BIN_ONE)
        else $error("bin index did not advance");

    a_bin_wrap:
    assert property (accept && (sweep_start || bin_q == BIN_LAST) |=>
                     bin_q == ($past(sweep_start) ? BIN_ONE : 12'h000))
        else $error("bin index did not wrap");

    a_push_lat:
    assert property (accept |=> s1_v_q && s1_bin_q == $past(cur_bin) && fifo_s_ready)
        else $error("result not pushed one cycle after accept");

    a_fir_only:
    assert property (s1_v_q && !mode_recursive |-> acc == fir_sum)
        else $error("feedback leaked into non-recursive result");

    a_iir_feed:
    assert property (s1_v_q && mode_recursive |-> acc == fir_sum + fb_sum)
        else $error("feedback missing in recursive result");

    a_fwd_new:
    assert property (s1_v_q && wr_en_q && wr_addr_q == s1_bin_q |-> hist == wr_data_q)
        else $error("pending write not forwarded");

    a_wr_stage:
    assert property (st_q == RGF_RUN && s1_v_q |=> wr_en_q && wr_addr_q == $past(s1_bin_q))
        else $error("registered write missing");

    a_shift_new:
    assert property (st_q == RGF_RUN && s1_v_q |=>
                     wr_data_q[H_X1 +: SMP_W] == $past(s1_x_q)
                     && wr_data_q[H_X2 +: SMP_W] == $past(h_x1))
        else $error("history not shifted");

    c_sweep: cover property (accept && sweep_start);
    c_fwd:   cover property (s1_v_q && fwd1);
    c_iir:   cover property (s1_v_q && mode_recursive);
    c_full:  cover property (st_q == RGF_RUN && smp_valid && !smp_ready_q);
endmodule

// [rgf_sink.sv]
// Purpose: Downstream consumer model for the range-gated filter results
// Assumes: Single core clock, bench drives stall and slow
// Notes:   Captured words are shown to the bench for one cycle

module rgf_sink (
    input  wire logic        core_clk,  // Core clock
    input  wire logic        srst,      // Synchronous reset
    input  wire logic        stall,     // Refuse every word
    input  wire logic        slow,      // Accept every other cycle
    input  wire logic        out_valid, // Result offered
    output logic             out_ready, // Result taken
    input  wire logic [35:0] out_data,  // Filtered value
    input  wire logic [11:0] out_bin,   // Bin of the result
    output logic             cap_stb,   // Word captured last edge
    output logic      [35:0] cap_data,  // Captured value
    output logic      [11:0] cap_bin    // Captured bin
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Ready changes off the sampling edge only
    initial out_ready = 1'b0;
    always @(negedge core_clk) begin
        out_ready <= (srst || stall) ? 1'b0 : (slow ? ~out_ready : 1'b1);
    end

    // Capture on the handshake edge
    always @(posedge core_clk) begin
        cap_stb  <= out_valid && out_ready && !srst;
        cap_data <= out_data;
        cap_bin  <= out_bin;
    end
endmodule

// [range_gated_fir_filter_bench.sv]
// Purpose: Self-checking bench for the range-gated filter
// Assumes: 50 MHz core clock, inputs driven at the falling edge
// Notes:   Per-bin history is predicted here and scoreboarded in order

module range_gated_fir_filter_bench
    import rgf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic sw; logic [15:0] x; logic rec; logic [11:0] bin;} rgf_row_t;

    logic                    core_clk, srst, smp_valid, smp_ready, sweep_start; // Controls
    logic                    mode_recursive, out_valid, out_ready;              // Mode, output
    logic                    stall, slow, cap_stb;                              // Sink controls
    logic signed [SMP_W-1:0] smp_data, c0, c1, c2, c3, f1, f2;                  // Data, weights
    logic        [ACC_W-1:0] out_data, cap_data;                                // Results
    logic        [BIN_W-1:0] out_bin, cap_bin;                                  // Result bins
    logic signed [15:0]      hx1 [BIN_CNT], hx2 [BIN_CNT], hx3 [BIN_CNT];       // Prior inputs
    logic signed [15:0]      hy1 [BIN_CNT], hy2 [BIN_CNT];                      // Prior outputs
    logic        [47:0]      exp_q [$];                                         // Expected words
    logic        [47:0]      sb_w;                                              // Popped word
    rgf_row_t                rows [10];                                         // Ordinary cases
    int                      num_errors, n_compared, n_acc;                     // Counters

    rgf_filter i_rgf_filter (.core_clk(core_clk), .srst(srst), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .sweep_start(sweep_start),
        .mode_recursive(mode_recursive), .coef_tap0(c0), .coef_tap1(c1), .coef_tap2(c2),
        .coef_tap3(c3), .coef_fb1(f1), .coef_fb2(f2), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_bin(out_bin));
    rgf_sink i_rgf_sink (.core_clk(core_clk), .srst(srst), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_bin(out_bin), .cap_stb(cap_stb), .cap_data(cap_data), .cap_bin(cap_bin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and closing tasks
    task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bin(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compared=%0d mismatches=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic stuck;
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model: four taps, optional feedback, history shift
    task automatic predict(input logic [11:0] b, input logic signed [15:0] x, input logic rec);
        logic signed [35:0] acc, sh;
        logic signed [15:0] st;
        acc = c0 * x + c1 * hx1[b] + c2 * hx2[b] + c3 * hx3[b];
        if (rec) begin
            acc = acc + f1 * hy1[b] + f2 * hy2[b];
        end
        sh = acc >>> 14;
        st = (sh > 36'sh000007FFF) ? 16'sh7FFF : (sh < 36'shFFFFF8000) ? 16'sh8000 : sh[15:0];
        hy2[b] = hy1[b];
        hy1[b] = st;
        hx3[b] = hx2[b];
        hx2[b] = hx1[b];
        hx1[b] = x;
        exp_q.push_back({b, acc});
    endtask

    // Offer one sample, wait for acceptance under a bound
    task automatic send(input logic sw, input logic [15:0] x, input logic rec,
                        input logic [11:0] b);
        int n;
        n = 0;
        smp_valid = 1'b1;
        smp_data = x;
        sweep_start = sw;
        mode_recursive = rec;
        while (smp_ready !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (smp_ready !== 1'b1) stuck();
        @(posedge core_clk);
        predict(b, x, rec);
        @(negedge core_clk);
    endtask

    // Release the input, data line shows a changed pattern
    task automatic idle;
        smp_valid = 1'b0;
        sweep_start = 1'b0;
        smp_data = ~smp_data;
        @(negedge core_clk);
    endtask

    // Wait until every expected word came out
    task automatic drain(input int lim);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (exp_q.size() != 0) stuck();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // In-order scoreboard on captured words
    always @(negedge core_clk) begin
        if (cap_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                stuck();
            end else begin
                sb_w = exp_q.pop_front();
                cmp_bin(cap_bin, sb_w[47:36]);
                cmp_data(cap_data, sb_w[35:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {srst, smp_valid, sweep_start, mode_recursive, stall, slow} = 6'h21;
        slow = 1'b0;
        smp_data = 16'h0000;
        {c0, c1, c2, c3} = {16'h4000, 16'h2000, 16'hE000, 16'h1000};
        {f1, f2} = {16'h2000, 16'hF000};
        num_errors = 0;
        n_compared = 0;
        for (int i = 0; i < BIN_CNT; i++) begin
            {hx1[i], hx2[i], hx3[i], hy1[i], hy2[i]} = 80'h0;
        end
        rows = '{'{1'b1, 16'h1000, 1'b0, 12'h000}, '{1'b0, 16'h2000, 1'b0, 12'h001},
                 '{1'b0, 16'hF000, 1'b0, 12'h002}, '{1'b1, 16'h7FFF, 1'b0, 12'h000},
                 '{1'b0, 16'h0100, 1'b0, 12'h001}, '{1'b1, 16'h8000, 1'b0, 12'h000},
                 '{1'b1, 16'h4000, 1'b1, 12'h000}, '{1'b0, 16'h3000, 1'b1, 12'h001},
                 '{1'b1, 16'h7FFF, 1'b1, 12'h000}, '{1'b1, 16'h7FFF, 1'b1, 12'h000}};
        // Reset, then 4000 cycles into the 4096-bin history clear
        repeat (20) @(negedge core_clk);
        cmp_flag(smp_ready, 1'b0);
        cmp_flag(out_valid, 1'b0);
        cmp_data(out_data, 36'h0);
        cmp_bin(out_bin, 12'h000);
        srst = 1'b0;
        repeat (4000) @(negedge core_clk);
        cmp_flag(smp_ready, 1'b0);
        $display("test reset done");
        // Ordinary cases: sweeps, history shift, both modes
        for (int i = 0; i < 10; i++) begin
            send(rows[i].sw, rows[i].x, rows[i].rec, rows[i].bin);
            idle();
        end
        drain(200);
        $display("test rows done");
        // Full sweep plus wrap, slow consumer, back to back
        slow = 1'b1;
        for (int k = 0; k <= BIN_CNT; k++) begin
            send(k == 0, 16'(k * 37) ^ 16'h0800, 1'b0, 12'(k));
        end
        idle();
        drain(20000);
        slow = 1'b0;
        $display("test wrap done");
        // Same bin every cycle, consumer stalled until refusal
        stall = 1'b1;
        n_acc = 0;
        for (int k = 0; k < 40; k++) begin
            {smp_valid, sweep_start, mode_recursive} = 3'h7;
            smp_data = 16'h7000 + 16'(k);
            if (smp_ready === 1'b1) begin
                @(posedge core_clk);
                predict(12'h000, smp_data, 1'b1);
                n_acc++;
            end else begin
                @(posedge core_clk);
            end
            @(negedge core_clk);
        end
        idle();
        cmp_flag(smp_ready, 1'b0);
        cmp_flag(out_valid, 1'b1);
        cmp_flag(n_acc == int'(READY_MAX) + 3, 1'b1);
        stall = 1'b0;
        drain(300);
        $display("test backpressure done");
        end_of_test();
    end
endmodule
